// file: pkg/lcsc_map.svh
// Offsets, field positions, reset values and timing counts of the link control block.
`ifndef LCSC_MAP_SVH
`define LCSC_MAP_SVH

// Byte offsets decoded from haddr[11:0].
`define LCSC_OFS_SET 12'h0e0
`define LCSC_OFS_CLEAR 12'h0e4
`define LCSC_OFS_STATUS 12'h0f0

// Field positions of the link control word.
`define LCSC_BIT_ROLL_EXT 22
`define LCSC_BIT_CYC_MASTER 21
`define LCSC_BIT_COUNT_EN 20
`define LCSC_BIT_PHY_RX 10
`define LCSC_BIT_SELF_RX 9
`define LCSC_BIT_SYNC_LOCK 6

// Reset value, bits that the set offset may raise, bits that the clear offset may drop.
`define LCSC_CTL_RESET 32'h0000_0000
`define LCSC_SET_MASK 32'h0070_0640
`define LCSC_CLEAR_MASK 32'h0070_0600

// Field positions of the status word.
`define LCSC_STAT_OFFSET_LSB 0
`define LCSC_STAT_OVERLONG 16
`define LCSC_STAT_EXT_LEVEL 17

// Clock rates in kHz and the length of one isochronous cycle.
`define LCSC_HCLK_KHZ 250000
`define LCSC_LINK_KHZ 24576
`define LCSC_CYCLE_TIME_US 125
`define LCSC_CYCLE_TICKS (`LCSC_CYCLE_TIME_US * `LCSC_LINK_KHZ / 1000)

// Number of isochronous receive contexts.
`define LCSC_IR_CONTEXTS 4

`endif

// file: pkg/lcsc_pkg.sv
// Types shared by the link control block.
package lcsc_pkg;

  typedef logic [31:0] lcsc_word_type;
  typedef logic [11:0] lcsc_offset_type;
  typedef logic [18:0] lcsc_acc_type;

  // Kind of register write pending in the bus data phase.
  typedef enum logic [2:0] {
    LCSC_WR_IDLE  = 3'b001,
    LCSC_WR_SET   = 3'b010,
    LCSC_WR_CLEAR = 3'b100
  } lcsc_wr_kind_type;

endpackage

// file: core/lcsc_rate_enable.sv
// Fractional divider that turns the bus clock into a one-cycle enable at a lower rate.
`timescale 1ns/1ps
module lcsc_rate_enable #(
  parameter lcsc_pkg::lcsc_acc_type STEP = 19'd1,
  parameter lcsc_pkg::lcsc_acc_type MODULUS = 19'd2
) (
  input wire logic hclk, // Bus clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  output logic tick // One-cycle enable at STEP/MODULUS of the clock rate.
);
  import lcsc_pkg::*;

  lcsc_acc_type acc_reg;
  lcsc_acc_type acc_sum;
  logic tick_reg;

  assign acc_sum = acc_reg + STEP;
  assign tick = tick_reg;

  // Phase accumulator: the pulse spacing jitters by one clock but averages exactly.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= 19'h0;
      tick_reg <= 1'b0;
    end else if (acc_sum >= MODULUS) begin
      acc_reg <= acc_sum - MODULUS;
      tick_reg <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      tick_reg <= 1'b0;
    end
  end

endmodule

// file: core/lcsc_cycle_counter.sv
// Cycle offset counter with internal or external rollover and resynchronisation load.
`timescale 1ns/1ps
`include "lcsc_map.svh"
module lcsc_cycle_counter (
  input wire logic hclk, // Bus clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic tick, // Link-rate enable pulse.
  input wire logic count_en, // Counter advances when high.
  input wire logic ext_select, // Roll over on ext_event instead of the count.
  input wire logic ext_event, // One-cycle external rollover event.
  input wire logic load, // Load load_value into the offset.
  input wire lcsc_pkg::lcsc_offset_type load_value, // Value taken on load.
  output lcsc_pkg::lcsc_offset_type offset, // Current cycle offset.
  output logic rollover // One-cycle pulse at each rollover.
);
  import lcsc_pkg::*;

  localparam lcsc_offset_type LAST = 12'(`LCSC_CYCLE_TICKS - 1);

  lcsc_offset_type offset_reg;
  logic rollover_reg;
  logic at_last;
  logic roll;

  assign at_last = (offset_reg == LAST);
  assign roll = count_en & (ext_select ? ext_event : (tick & at_last));
  assign offset = offset_reg;
  assign rollover = rollover_reg;

  // With the count disabled the offset holds except on a load, and no rollover is raised.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      offset_reg <= 12'h000;
    end else if (load) begin
      offset_reg <= load_value;
    end else if (roll) begin
      offset_reg <= 12'h000;
    end else if (count_en && tick) begin
      offset_reg <= at_last ? 12'h000 : offset_reg + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rollover_reg <= 1'b0;
    end else begin
      rollover_reg <= roll;
    end
  end

endmodule

// file: core/lcsc_link_control.sv
// Link control set/clear register with its cycle timer, receive gating and filter lock.
`timescale 1ns/1ps
`include "lcsc_map.svh"
module lcsc_link_control (
  input wire logic hclk, // Bus clock, 250 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire lcsc_pkg::lcsc_word_type haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, words only.
  input wire logic hready, // Bus ready.
  input wire lcsc_pkg::lcsc_word_type hwdata, // Write data.
  output logic hreadyout, // Slave ready.
  output lcsc_pkg::lcsc_word_type hrdata, // Read data.
  output logic hresp, // Response, always OKAY.
  input wire logic global_reset_input, // Synchronous global reset, active high.
  input wire logic external_cycle_input, // External cycle input, rising edge counts.
  input wire logic overlong_cycle_event, // Overlong-cycle event flag level.
  input wire logic cycle_start_rx, // Pulse: cycle start packet received.
  input wire lcsc_pkg::lcsc_offset_type cycle_start_rx_offset, // Offset carried by it.
  input wire logic ar_request_context_enabled, // Receive request context is running.
  input wire logic phy_packet_arrived, // Pulse: PHY packet arrived.
  input wire logic self_ident_packet_arrived, // Pulse: self-ID packet arrived.
  input wire logic [`LCSC_IR_CONTEXTS-1:0] tag_one_sync_filter_sw, // Software filter bits.
  output logic rollover_external_select, // Control bit 22.
  output logic cycle_start_generator_enable, // Control bit 21.
  output logic cycle_offset_count_enable, // Control bit 20.
  output logic phy_packet_receive_enable, // Control bit 10.
  output logic self_ident_receive_enable, // Control bit 9.
  output logic sync_filter_force_lock, // Control bit 6.
  output lcsc_pkg::lcsc_offset_type cycle_offset, // Cycle offset count.
  output logic cycle_rollover, // Pulse at each cycle rollover.
  output logic cycle_start_emit, // Pulse: send a cycle start packet.
  output logic phy_packet_accept, // Pulse: PHY packet taken.
  output logic self_ident_accept, // Pulse: self-ID packet taken.
  output logic [`LCSC_IR_CONTEXTS-1:0] tag_one_sync_filter // Effective filter bits.
);
  import lcsc_pkg::*;

  localparam lcsc_acc_type LINK_STEP = 19'(`LCSC_LINK_KHZ);
  localparam lcsc_acc_type LINK_MODULUS = 19'(`LCSC_HCLK_KHZ);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  lcsc_word_type ctl_reg;
  lcsc_word_type ctl_next;
  lcsc_word_type status_word;
  lcsc_word_type read_value;
  lcsc_wr_kind_type wr_kind_reg;
  lcsc_wr_kind_type wr_kind_next;
  lcsc_word_type hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic addr_phase;
  logic hit_set;
  logic hit_clear;
  logic hit_status;
  logic link_tick;
  logic ext_prev_reg;
  logic ext_event;
  logic resync;
  lcsc_offset_type offset_value;
  logic rollover_value;
  logic cycle_start_emit_reg;
  logic phy_packet_accept_reg;
  logic self_ident_accept_reg;
  logic [`LCSC_IR_CONTEXTS-1:0] tag_filter_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus address phase decode.

  assign addr_phase = hsel & hready & htrans[1];
  assign hit_set = (haddr[11:0] == `LCSC_OFS_SET);
  assign hit_clear = (haddr[11:0] == `LCSC_OFS_CLEAR);
  assign hit_status = (haddr[11:0] == `LCSC_OFS_STATUS);

  always_comb begin
    wr_kind_next = LCSC_WR_IDLE;
    if (addr_phase && hwrite) begin
      if (hit_set) begin
        wr_kind_next = LCSC_WR_SET;
      end else if (hit_clear) begin
        wr_kind_next = LCSC_WR_CLEAR;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_kind_reg <= LCSC_WR_IDLE;
    end else begin
      wr_kind_reg <= wr_kind_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next value of the control word.

  // The write lands in the data phase; a hardware clear of bit 21 beats a set
  // in the same cycle, and the global reset input beats everything.
  always_comb begin
    ctl_next = ctl_reg;
    case (wr_kind_reg)
      LCSC_WR_IDLE: begin
        ctl_next = ctl_reg;
      end
      LCSC_WR_SET: begin
        ctl_next = ctl_reg | (hwdata & `LCSC_SET_MASK);
      end
      LCSC_WR_CLEAR: begin
        ctl_next = ctl_reg & ~(hwdata & `LCSC_CLEAR_MASK);
      end
      default: begin
        ctl_next = ctl_reg;
      end
    endcase
    if (overlong_cycle_event) begin
      ctl_next[`LCSC_BIT_CYC_MASTER] = 1'b0;
    end
    if (global_reset_input) begin
      ctl_next = `LCSC_CTL_RESET;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_reg <= `LCSC_CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign rollover_external_select = ctl_reg[`LCSC_BIT_ROLL_EXT];
  assign cycle_start_generator_enable = ctl_reg[`LCSC_BIT_CYC_MASTER];
  assign cycle_offset_count_enable = ctl_reg[`LCSC_BIT_COUNT_EN];
  assign phy_packet_receive_enable = ctl_reg[`LCSC_BIT_PHY_RX];
  assign self_ident_receive_enable = ctl_reg[`LCSC_BIT_SELF_RX];
  assign sync_filter_force_lock = ctl_reg[`LCSC_BIT_SYNC_LOCK];

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`LCSC_STAT_OFFSET_LSB +: 12] = offset_value;
    status_word[`LCSC_STAT_OVERLONG] = overlong_cycle_event;
    status_word[`LCSC_STAT_EXT_LEVEL] = external_cycle_input;
  end

  // Reads see ctl_next so that a write still in its data phase is not missed.
  always_comb begin
    read_value = 32'h0000_0000;
    if (hit_set || hit_clear) begin
      read_value = ctl_next;
    end else if (hit_status) begin
      read_value = status_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= read_value;
    end
  end

  // Every transfer completes without wait states and with an OKAY response.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle timer.

  lcsc_rate_enable #(
    .STEP(LINK_STEP),
    .MODULUS(LINK_MODULUS)
  ) u_link_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(link_tick)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= external_cycle_input;
    end
  end

  assign ext_event = external_cycle_input & ~ext_prev_reg;

  // A node that is not cycle master follows the cycle starts of the root.
  assign resync = cycle_start_rx & ~ctl_reg[`LCSC_BIT_CYC_MASTER];

  lcsc_cycle_counter u_cycle_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(link_tick),
    .count_en(ctl_reg[`LCSC_BIT_COUNT_EN]),
    .ext_select(ctl_reg[`LCSC_BIT_ROLL_EXT]),
    .ext_event(ext_event),
    .load(resync),
    .load_value(cycle_start_rx_offset),
    .offset(offset_value),
    .rollover(rollover_value)
  );

  assign cycle_offset = offset_value;
  assign cycle_rollover = rollover_value;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_start_emit_reg <= 1'b0;
    end else begin
      cycle_start_emit_reg <= rollover_value & ctl_reg[`LCSC_BIT_CYC_MASTER];
    end
  end

  assign cycle_start_emit = cycle_start_emit_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive gating.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_packet_accept_reg <= 1'b0;
    end else begin
      phy_packet_accept_reg <= phy_packet_arrived & ctl_reg[`LCSC_BIT_PHY_RX]
        & ar_request_context_enabled;
    end
  end

  // Self-ID acceptance looks only at its own enable, never at the PHY packet bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      self_ident_accept_reg <= 1'b0;
    end else begin
      self_ident_accept_reg <= self_ident_packet_arrived
        & ctl_reg[`LCSC_BIT_SELF_RX];
    end
  end

  assign phy_packet_accept = phy_packet_accept_reg;
  assign self_ident_accept = self_ident_accept_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Tag-1 sync filter of the isochronous receive contexts.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tag_filter_reg <= '0;
    end else if (ctl_reg[`LCSC_BIT_SYNC_LOCK]) begin
      tag_filter_reg <= '1;
    end else begin
      tag_filter_reg <= tag_one_sync_filter_sw;
    end
  end

  assign tag_one_sync_filter = tag_filter_reg;

endmodule

// file: bench/lcsc_link_control_asserts.sv
// Concurrent checks on the ports of the link control block.
`timescale 1ns/1ps
`include "lcsc_map.svh"
module lcsc_link_control_chk (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic hsel, // Select.
  input wire lcsc_pkg::lcsc_word_type haddr, // Address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write.
  input wire logic hready, // Ready in.
  input wire lcsc_pkg::lcsc_word_type hrdata, // Read data.
  input wire logic global_reset_input, // Global reset.
  input wire logic external_cycle_input, // External cycle.
  input wire logic overlong_cycle_event, // Overlong flag.
  input wire logic cycle_start_rx, // Received cycle start.
  input wire logic ar_request_context_enabled, // Context on.
  input wire logic phy_packet_arrived, // PHY packet.
  input wire logic self_ident_packet_arrived, // Self-ID packet.
  input wire logic [`LCSC_IR_CONTEXTS-1:0] tag_one_sync_filter_sw, // Software bits.
  input wire logic rollover_external_select, // Bit 22.
  input wire logic cycle_start_generator_enable, // Bit 21.
  input wire logic cycle_offset_count_enable, // Bit 20.
  input wire logic phy_packet_receive_enable, // Bit 10.
  input wire logic self_ident_receive_enable, // Bit 9.
  input wire logic sync_filter_force_lock, // Bit 6.
  input wire lcsc_pkg::lcsc_offset_type cycle_offset, // Offset.
  input wire logic cycle_rollover, // Rollover.
  input wire logic cycle_start_emit, // Cycle start.
  input wire logic phy_packet_accept, // PHY taken.
  input wire logic self_ident_accept, // Self-ID taken.
  input wire logic [`LCSC_IR_CONTEXTS-1:0] tag_one_sync_filter // Effective bits.
);
  import lcsc_pkg::*;
  logic rd_ctl_reg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Marks the data phase of a read at the set or clear offset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_ctl_reg <= 1'b0;
    else rd_ctl_reg <= hsel && hready && htrans[1] && !hwrite && haddr[11:3] == 9'h01c;
  end
  a_reserved_zero: assert property (rd_ctl_reg |-> (hrdata & ~32'h0070_0640) == 32'h0)
    else $error("reserved bits read nonzero");
  a_overlong_clears: assert property (overlong_cycle_event |=> !cycle_start_generator_enable)
    else $error("cycle start enable kept while overlong");
  a_lock_kept: assert property (sync_filter_force_lock && !global_reset_input |=> sync_filter_force_lock)
    else $error("filter lock dropped");
  a_global_reset_input_clears: assert property (global_reset_input |=> !sync_filter_force_lock && !cycle_offset_count_enable)
    else $error("global reset left control bits");
  a_filter_forced: assert property (sync_filter_force_lock |=> tag_one_sync_filter == 4'hf)
    else $error("filter not forced");
  a_filter_free: assert property (!sync_filter_force_lock |=> tag_one_sync_filter == $past(tag_one_sync_filter_sw))
    else $error("filter not software value");
  a_offset_held: assert property (!cycle_offset_count_enable && !cycle_start_rx |=> $stable(cycle_offset))
    else $error("offset moved while disabled");
  a_offset_range: assert property (cycle_offset <= 12'd3071)
    else $error("offset beyond wrap");
  a_emit_follows: assert property (cycle_rollover && cycle_start_generator_enable && !overlong_cycle_event |=> cycle_start_emit)
    else $error("no cycle start after rollover");
  a_ext_rollover: assert property ($rose(external_cycle_input) && rollover_external_select && cycle_offset_count_enable |-> ##[1:3] cycle_rollover)
    else $error("no rollover on external event");
  a_phy_accept: assert property (phy_packet_arrived && phy_packet_receive_enable && ar_request_context_enabled |=> phy_packet_accept)
    else $error("PHY packet not taken");
  a_self_gate: assert property (self_ident_accept |-> $past(self_ident_receive_enable && self_ident_packet_arrived))
    else $error("self-ID taken while disabled");
  c_emit: cover property (cycle_start_emit);
  c_phy: cover property (phy_packet_accept);
  c_ext: cover property (cycle_rollover && rollover_external_select);
endmodule
bind lcsc_link_control lcsc_link_control_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .global_reset_input, .external_cycle_input, .overlong_cycle_event,
  .cycle_start_rx,
  .ar_request_context_enabled, .phy_packet_arrived, .self_ident_packet_arrived,
  .tag_one_sync_filter_sw, .rollover_external_select, .cycle_start_generator_enable,
  .cycle_offset_count_enable, .phy_packet_receive_enable, .self_ident_receive_enable,
  .sync_filter_force_lock, .cycle_offset, .cycle_rollover, .cycle_start_emit,
  .phy_packet_accept, .self_ident_accept, .tag_one_sync_filter);

// file: bench/lcsc_link_control_tb.sv
// Self-checking bench for the link control block.
`timescale 1ns/1ps
module lcsc_link_control_tb;
  import lcsc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  lcsc_word_type haddr = 32'h0, hwdata = 32'h0, hrdata, ctl = 32'h0, d;
  logic global_reset_input = 1'b0, external_cycle_input = 1'b0, overlong_cycle_event = 1'b0;
  logic cycle_start_rx = 1'b0, ar_request_context_enabled = 1'b0, phy_packet_arrived = 1'b0;
  logic self_ident_packet_arrived = 1'b0;
  lcsc_offset_type cycle_start_rx_offset = 12'h0, cycle_offset;
  logic [3:0] tag_one_sync_filter_sw = 4'h0, tag_one_sync_filter;
  logic rollover_external_select, cycle_start_generator_enable, cycle_offset_count_enable;
  logic phy_packet_receive_enable, self_ident_receive_enable, sync_filter_force_lock;
  logic cycle_rollover, cycle_start_emit, phy_packet_accept, self_ident_accept;
  int err_total = 0, checks = 0, seed = 32'h8c23, n;
  always #2 hclk = ~hclk;
  lcsc_link_control DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hreadyout, .hrdata, .hresp, .global_reset_input,
    .external_cycle_input, .overlong_cycle_event, .cycle_start_rx, .cycle_start_rx_offset,
    .ar_request_context_enabled, .phy_packet_arrived, .self_ident_packet_arrived,
    .tag_one_sync_filter_sw, .rollover_external_select, .cycle_start_generator_enable,
    .cycle_offset_count_enable, .phy_packet_receive_enable, .self_ident_receive_enable,
    .sync_filter_force_lock, .cycle_offset, .cycle_rollover, .cycle_start_emit,
    .phy_packet_accept, .self_ident_accept, .tag_one_sync_filter);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_w(input string nm, input lcsc_word_type e, input lcsc_word_type g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_b(input string nm, input logic e, input logic g);
    cmp_w(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic complete_run;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One single transfer; the address phase is held until ready is seen high.
  task automatic bus(input logic wr, input lcsc_offset_type a, input lcsc_word_type wd,
      output lcsc_word_type q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input lcsc_offset_type a, input lcsc_word_type e);
    lcsc_word_type q;
    bus(1'b0, a, 32'h0, q);
    cmp_w("read data", e, q);
    cmp_b("response", 1'b0, hresp);
  endtask
  // Writes through the set or clear offset, updates the model and checks the control pins.
  task automatic wctl(input logic clr, input lcsc_word_type v);
    lcsc_word_type q;
    bus(1'b1, clr ? 12'h0e4 : 12'h0e0, v, q);
    if (clr) ctl = ctl & ~(v & 32'h0070_0600);
    else ctl = ctl | (v & 32'h0070_0640 & (overlong_cycle_event ? 32'hffdf_ffff : 32'hffff_ffff));
    #1 cmp_w("control", ctl, {9'h0, rollover_external_select, cycle_start_generator_enable,
      cycle_offset_count_enable, 9'h0, phy_packet_receive_enable, self_ident_receive_enable,
      2'h0, sync_filter_force_lock, 6'h0});
  endtask
  task automatic wait_roll(output int c);
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (cycle_rollover !== 1'b1 && c < 40000);
  endtask
  task automatic chk_filter;
    repeat (3) @(posedge hclk);
    cmp_w("filter", {28'h0, ctl[6] ? 4'hf : tag_one_sync_filter_sw}, {28'h0, tag_one_sync_filter});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge hclk);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(12'h0e0, 32'h0);
    rd(12'h0e4, 32'h0);
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      tag_one_sync_filter_sw <= d[7:4];
      wctl(d[0], d);
      rd(d[1] ? 12'h0e4 : 12'h0e0, ctl);
      chk_filter();
    end
    wctl(1'b0, 32'h0000_0040);
    wctl(1'b1, 32'hffff_ffff);
    wctl(1'b1, 32'h0);
    bus(1'b1, 12'h0e8, 32'hffff_ffff, d);
    rd(12'h0e8, 32'h0);
    rd(12'h0e0, ctl);
    @(posedge hclk);
    global_reset_input <= 1'b1;
    @(posedge hclk);
    global_reset_input <= 1'b0;
    ctl = 32'h0;
    rd(12'h0e0, ctl);
    chk_filter();
    wctl(1'b0, 32'h0020_0000);
    overlong_cycle_event <= 1'b1;
    ctl[21] = 1'b0;
    wctl(1'b0, 32'h0020_0000);
    overlong_cycle_event <= 1'b0;
    wctl(1'b0, 32'h0030_0000);
    wait_roll(n);
    wait_roll(n);
    cmp_w("period", 32'd31250, n);
    @(posedge hclk);
    cmp_b("cycle start", 1'b1, cycle_start_emit);
    wctl(1'b1, 32'h0010_0000);
    d = {20'h0, cycle_offset};
    repeat (40) @(posedge hclk);
    cmp_w("held offset", d, {20'h0, cycle_offset});
    wctl(1'b0, 32'h0050_0000);
    external_cycle_input <= 1'b1;
    wait_roll(n);
    external_cycle_input <= 1'b0;
    cmp_b("external rollover", 1'b1, n < 5);
    @(posedge hclk);
    cmp_b("cycle start", 1'b1, cycle_start_emit);
    wctl(1'b1, 32'h0070_0000);
    d = $random(seed);
    cycle_start_rx <= 1'b1;
    cycle_start_rx_offset <= d[11:0] % 12'd3072;
    @(posedge hclk);
    cycle_start_rx <= 1'b0;
    @(posedge hclk);
    cmp_w("loaded offset", {20'h0, d[11:0] % 12'd3072}, {20'h0, cycle_offset});
    for (int k = 0; k < 8; k++) begin
      wctl(1'b1, 32'h0000_0600);
      wctl(1'b0, {21'h0, k[1:0], 9'h0});
      ar_request_context_enabled <= k[2];
      phy_packet_arrived <= 1'b1;
      self_ident_packet_arrived <= 1'b1;
      @(posedge hclk);
      phy_packet_arrived <= 1'b0;
      self_ident_packet_arrived <= 1'b0;
      @(posedge hclk);
      cmp_b("phy accept", k[1] & k[2], phy_packet_accept);
      cmp_b("self accept", k[0], self_ident_accept);
    end
    complete_run();
  end
endmodule
